// file: dsat_channel.sv
// Purpose: one alarm channel: comparison, delay and hold sequencing
// Assumes: settings already clamped to their legal ranges
// Notes:   times count whole seconds from the shared tick
`timescale 1ns/1ns
module dsat_channel
   import dsat_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [15:0] process_value,
   input wire logic signed [15:0] setpoint,
   input wire logic signed [15:0] band_width,
   input wire logic [2:0] function_select,
   input wire logic block_in,
   input wire logic [9:0] hold_time,
   input wire logic [9:0] trigger_delay,
   input wire logic sec_tick,
   output logic condition,
   output logic relay,
   output logic trig_pulse,
   output logic cond_rise
);
   // ************************************************
   // comparison
   // ************************************************
   logic signed [17:0] pv;
   logic signed [17:0] sp;
   logic signed [17:0] half;
   logic below;
   logic above;
   logic outside;
   logic cond;

   // band centred on the set point, half width each side
   always_comb begin
      pv = 18'(process_value);
      sp = 18'(setpoint);
      half = 18'(band_width) >>> 1;
      below = pv < sp;
      above = pv > sp;
      outside = (pv < sp - half) || (pv > sp + half);
      case (function_select)
         FN_BELOW: cond = below;
         FN_ABOVE: cond = above;
         FN_BAND: cond = outside;
         FN_BELOW_BLK: cond = below && !block_in;
         FN_ABOVE_BLK: cond = above && !block_in;
         FN_BAND_BLK: cond = outside && !block_in;
         default: cond = 1'b0;
      endcase
   end

   // ************************************************
   // delay and hold sequencer
   // ************************************************
   dsat_state_e state_ff;
   dsat_state_e nxt_state;
   logic [9:0] secs_ff;
   logic [9:0] nxt_secs;
   logic cond_ff;
   logic trig_ff;
   logic nxt_trig;

   // hold 0 keeps the relay while the condition lasts;
   // the first second may be short since the tick runs free
   always_comb begin
      nxt_state = state_ff;
      nxt_secs = secs_ff;
      nxt_trig = 1'b0;
      if (sec_tick)
         nxt_secs = secs_ff + 10'h001;
      case (state_ff)
         DSAT_IDLE: begin
            nxt_secs = 10'h000;
            if (cond && trigger_delay == 10'h000) begin
               nxt_state = DSAT_ON;
               nxt_trig = 1'b1;
            end else if (cond)
               nxt_state = DSAT_DELAY;
         end
         DSAT_DELAY: begin
            if (!cond)
               nxt_state = DSAT_IDLE;
            else if (secs_ff >= trigger_delay) begin
               nxt_state = DSAT_ON;
               nxt_secs = 10'h000;
               nxt_trig = 1'b1;
            end
         end
         DSAT_ON: begin
            if (hold_time == 10'h000) begin
               if (!cond)
                  nxt_state = DSAT_IDLE;
            end else if (secs_ff >= hold_time)
               nxt_state = cond ? DSAT_SPENT : DSAT_IDLE;
         end
         DSAT_SPENT: begin
            if (!cond)
               nxt_state = DSAT_IDLE;
         end
         default: nxt_state = DSAT_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_ff <= DSAT_IDLE;
         secs_ff <= 10'h000;
         cond_ff <= 1'b0;
         trig_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         secs_ff <= nxt_secs;
         cond_ff <= cond;
         trig_ff <= nxt_trig;
      end
   end

   assign condition = cond_ff;
   assign relay = (state_ff == DSAT_ON);
   assign trig_pulse = trig_ff;
   assign cond_rise = cond && !cond_ff;
endmodule : dsat_channel

// file: dsat_monitor.sv
// Purpose: port checker of the dual set-point alarm timer
// Assumes: hready is fed back from hreadyout
// Notes:   bound to dsat_top, sees its ports only
`timescale 1ns/1ns
module dsat_monitor
   import dsat_pkg::*;
#(
   parameter int TICK_CYCLES = SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [1:0] relay_out,
   input wire logic chan1_indicator,
   input wire logic chan2_indicator,
   input wire logic irq
);
   // ********
   // helpers
   // ********
   logic take;
   logic wr_take;
   logic mask_seen_ff;
   logic nxt_mask_seen;
   // transfer taken at this edge
   assign take = hsel && hready && htrans[1];
   assign wr_take = take && hwrite;
   // irq cannot be on before any mask write has been addressed
   always_comb begin
      nxt_mask_seen = mask_seen_ff;
      if (wr_take && haddr == {24'h0, OFF_IRQ_MASK}) begin
         nxt_mask_seen = 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mask_seen_ff <= 1'b0;
      end else begin
         mask_seen_ff <= nxt_mask_seen;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ********
   // checks
   // ********
   ready_high_a: assert property (hreadyout)
      else $error("hreadyout low");
   okay_resp_a: assert property (!hresp)
      else $error("hresp not okay");
   read_idle_a: assert property (!(take && !hwrite) |=> hrdata == 32'h0)
      else $error("hrdata not zero outside a read");
   unmapped_read_a: assert property
      (take && !hwrite && haddr[31:8] != 24'h0 |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   reset_quiet_a: assert property ($rose(rst_n) |->
      relay_out == 2'h0 && !irq ##1
      (relay_out == 2'h0 && !chan1_indicator && !chan2_indicator))
      else $error("outputs active right after reset");
   relay1_rise_a: assert property ($rose(relay_out[0]) |-> chan1_indicator)
      else $error("relay 1 on without its condition");
   relay2_rise_a: assert property ($rose(relay_out[1]) |-> chan2_indicator)
      else $error("relay 2 on without its condition");
   irq_quiet_a: assert property (!mask_seen_ff |-> !irq)
      else $error("irq high with reset mask");
   irq_drop_a: assert property ($fell(irq) |-> $past(wr_take, 2))
      else $error("irq fell without a bus write");
   relay1_on_c: cover property ($rose(relay_out[0]));
   relay2_on_c: cover property ($rose(relay_out[1]));
   irq_on_c: cover property ($rose(irq));
endmodule : dsat_monitor
bind dsat_top dsat_monitor #(.TICK_CYCLES(TICK_CYCLES)) i_dsat_monitor (
   .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
   .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .relay_out(relay_out),
   .chan1_indicator(chan1_indicator), .chan2_indicator(chan2_indicator),
   .irq(irq));

// file: dsat_partner.sv
// Purpose: measurement path stand-in for the alarm timer
// Assumes: bench asks for a value and a block level
// Notes:   outputs change only just after a rising edge or when rst_n falls
`timescale 1ns/1ns
module dsat_partner (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic signed [15:0] want_value,
   input wire logic want_block,
   output logic signed [15:0] process_value,
   output logic [1:0] digital_in
);
   // registered so each sample is steady for a whole cycle
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         process_value <= 16'sh0;
         digital_in <= 2'h0;
      end else begin
         process_value <= want_value;
         digital_in <= {2{want_block}};
      end
   end
endmodule : dsat_partner

// file: dsat_pkg.sv
// Purpose: shared constants and types of the dual set-point alarm timer
// Assumes: 250 MHz system clock, 32-bit AHB-Lite register bus
// Notes:   byte offsets, field positions, reset values and time limits
package dsat_pkg;
   // ************************************************
   // clock and time
   // ************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int SECOND_NS = 1000000000;
   localparam int SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;
   localparam logic [9:0] TIME_MAX_S = 10'h3E8;   // 1000 s
   // ************************************************
   // value ranges
   // ************************************************
   localparam logic signed [15:0] VAL_MIN = -16'sd9999;
   localparam logic signed [15:0] VAL_MAX = 16'sd30000;
   // ************************************************
   // register map, byte offsets
   // ************************************************
   localparam logic [7:0] CH_STRIDE = 8'h20;      // channel 2 base
   localparam logic [4:0] OFF_SETPOINT = 5'h00;
   localparam logic [4:0] OFF_FUNCTION = 5'h04;
   localparam logic [4:0] OFF_BAND = 5'h08;
   localparam logic [4:0] OFF_HOLD = 5'h0C;
   localparam logic [4:0] OFF_DELAY = 5'h10;
   localparam logic [7:0] OFF_STATUS = 8'h40;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h44;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h48;
   // status fields: condition at 1:0, relay at 3:2
   localparam int ST_COND_POS = 0;
   localparam int ST_RELAY_POS = 2;
   // irq fields: trigger at 1:0, condition rise at 3:2
   localparam int IRQ_TRIG_POS = 0;
   localparam int IRQ_RISE_POS = 2;
   // ************************************************
   // reset values
   // ************************************************
   localparam logic signed [15:0] RST_SETPOINT = 16'sh0000;
   localparam logic signed [15:0] RST_BAND = 16'sh0000;
   localparam logic [2:0] RST_FUNCTION = 3'h0;
   localparam logic [9:0] RST_TIME = 10'h000;
   localparam logic [3:0] RST_IRQ_MASK = 4'h0;
   // ************************************************
   // function selection
   // ************************************************
   localparam logic [2:0] FN_OFF = 3'h0;
   localparam logic [2:0] FN_BELOW = 3'h1;
   localparam logic [2:0] FN_ABOVE = 3'h2;
   localparam logic [2:0] FN_BAND = 3'h3;
   localparam logic [2:0] FN_BELOW_BLK = 3'h4;
   localparam logic [2:0] FN_ABOVE_BLK = 3'h5;
   localparam logic [2:0] FN_BAND_BLK = 3'h6;
   // relay sequencer states, one-hot
   typedef enum logic [3:0] {
      DSAT_IDLE = 4'h1,
      DSAT_DELAY = 4'h2,
      DSAT_ON = 4'h4,
      DSAT_SPENT = 4'h8
   } dsat_state_e;
endpackage : dsat_pkg

// file: dsat_tick.sv
// Purpose: one-cycle pulse once per second
// Assumes: clk at the package clock period
// Notes:   period is a parameter so simulation may shorten it
`timescale 1ns/1ns
module dsat_tick
   import dsat_pkg::*;
#(
   parameter int CYCLES = SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   output logic tick
);
   logic [31:0] cnt_ff;
   logic [31:0] nxt_cnt;
   logic tick_ff;
   logic nxt_tick;

   // free-running prescaler, wraps at CYCLES-1
   always_comb begin
      nxt_tick = (cnt_ff == 32'(CYCLES - 1));
      nxt_cnt = nxt_tick ? 32'h00000000 : cnt_ff + 32'h00000001;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= 32'h00000000;
         tick_ff <= 1'b0;
      end else begin
         cnt_ff <= nxt_cnt;
         tick_ff <= nxt_tick;
      end
   end

   assign tick = tick_ff;
endmodule : dsat_tick

// file: dsat_top.sv
// Purpose: dual set-point alarm timer with AHB-Lite registers
// Assumes: process value and digital inputs synchronous to clk
// Notes:   zero-wait-state slave, response always OKAY
//
// How it works
// - two independent channels, own relay and LED
// - set point; below and above comparisons
// - band mode: outside window around set point
// - blocked variants need digital input deactivated
// - signed band width, -9999 to 30000
// - relay stays on for hold time
// - trigger delay counted from condition true
// - second channel identical, own settings
// - LED follows condition, not relay
// - timing may drop relay while condition holds
`timescale 1ns/1ns
module dsat_top
   import dsat_pkg::*;
#(
   parameter int TICK_CYCLES = SEC_CYCLES
) (
   input wire logic clk,
   input wire logic rst_n,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // measurement side
   input wire logic signed [15:0] process_value,
   input wire logic [1:0] digital_in,
   // load side
   output logic [1:0] relay_out,
   output logic chan1_indicator,
   output logic chan2_indicator,
   output logic irq
);
   // ************************************************
   // reset release
   // ************************************************
   logic rst_meta_ff;
   logic rst_sync_ff;
   logic srst_n;

   // asynchronous assert, release after two edges
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_meta_ff <= 1'b0;
         rst_sync_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_sync_ff <= rst_meta_ff;
      end
   end

   assign srst_n = rst_sync_ff;

   // ************************************************
   // helpers
   // ************************************************
   // out-of-range value and time writes saturate rather than wrap
   function automatic logic signed [15:0] clamp_val(
      input logic [31:0] w
   );
      logic signed [31:0] v;
      v = signed'(w);
      if (v < 32'(VAL_MIN))
         clamp_val = VAL_MIN;
      else if (v > 32'(VAL_MAX))
         clamp_val = VAL_MAX;
      else
         clamp_val = v[15:0];
   endfunction : clamp_val

   function automatic logic [9:0] clamp_time(
      input logic [31:0] w
   );
      if (w > 32'(TIME_MAX_S))
         clamp_time = TIME_MAX_S;
      else
         clamp_time = w[9:0];
   endfunction : clamp_time

   // ************************************************
   // bus address phase
   // ************************************************
   logic addr_take;
   logic wr_pend_ff;
   logic nxt_wr_pend;
   logic [7:0] wr_addr_ff;
   logic [7:0] nxt_wr_addr;
   logic addr_hi_zero;

   // only NONSEQ or SEQ with select and bus ready are taken
   always_comb begin
      addr_take = hsel && hready && htrans[1];
      addr_hi_zero = (haddr[31:8] == 24'h000000);
      nxt_wr_pend = addr_take && hwrite && addr_hi_zero;
      nxt_wr_addr = addr_take ? haddr[7:0] : wr_addr_ff;
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         wr_pend_ff <= 1'b0;
         wr_addr_ff <= 8'h00;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_addr_ff <= nxt_wr_addr;
      end
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   // ************************************************
   // configuration registers
   // ************************************************
   logic signed [15:0] sp_ff [2];
   logic signed [15:0] nxt_sp [2];
   logic signed [15:0] band_ff [2];
   logic signed [15:0] nxt_band [2];
   logic [2:0] fn_ff [2];
   logic [2:0] nxt_fn [2];
   logic [9:0] hold_ff [2];
   logic [9:0] nxt_hold [2];
   logic [9:0] dly_ff [2];
   logic [9:0] nxt_dly [2];
   logic [3:0] mask_ff;
   logic [3:0] nxt_mask;
   logic [3:0] istat_ff;
   logic [3:0] nxt_istat;
   logic [3:0] events;
   logic [3:0] w1c;
   logic wr_chan;
   logic ch_sel;
   logic [4:0] ch_off;

   // writes land in the data phase, using the held address
   always_comb begin
      wr_chan = wr_pend_ff && (wr_addr_ff[7:6] == 2'h0);
      ch_sel = wr_addr_ff[5];
      ch_off = wr_addr_ff[4:0];
      nxt_mask = mask_ff;
      w1c = 4'h0;
      for (int i = 0; i < 2; i++) begin
         nxt_sp[i] = sp_ff[i];
         nxt_band[i] = band_ff[i];
         nxt_fn[i] = fn_ff[i];
         nxt_hold[i] = hold_ff[i];
         nxt_dly[i] = dly_ff[i];
         if (wr_chan && ch_sel == i[0]) begin
            case (ch_off)
               OFF_SETPOINT: nxt_sp[i] = clamp_val(hwdata);
               OFF_BAND: nxt_band[i] = clamp_val(hwdata);
               OFF_FUNCTION: nxt_fn[i] = hwdata[2:0];
               OFF_HOLD: nxt_hold[i] = clamp_time(hwdata);
               OFF_DELAY: nxt_dly[i] = clamp_time(hwdata);
               default: ;
            endcase
         end
      end
      if (wr_pend_ff && wr_addr_ff == OFF_IRQ_MASK)
         nxt_mask = hwdata[3:0];
      if (wr_pend_ff && wr_addr_ff == OFF_IRQ_STAT)
         w1c = hwdata[3:0];
      // a new event beats a simultaneous clear
      nxt_istat = (istat_ff & ~w1c) | events;
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         for (int i = 0; i < 2; i++) begin
            sp_ff[i] <= RST_SETPOINT;
            band_ff[i] <= RST_BAND;
            fn_ff[i] <= RST_FUNCTION;
            hold_ff[i] <= RST_TIME;
            dly_ff[i] <= RST_TIME;
         end
         mask_ff <= RST_IRQ_MASK;
         istat_ff <= 4'h0;
      end else begin
         for (int i = 0; i < 2; i++) begin
            sp_ff[i] <= nxt_sp[i];
            band_ff[i] <= nxt_band[i];
            fn_ff[i] <= nxt_fn[i];
            hold_ff[i] <= nxt_hold[i];
            dly_ff[i] <= nxt_dly[i];
         end
         mask_ff <= nxt_mask;
         istat_ff <= nxt_istat;
      end
   end

   // ************************************************
   // alarm channels
   // ************************************************
   logic sec_tick;
   logic [1:0] cond;
   logic [1:0] relay;
   logic [1:0] trig;
   logic [1:0] rise;

   // one shared second tick keeps both channels in step
   dsat_tick #(
      .CYCLES(TICK_CYCLES)
   ) u_tick (
      .clk(clk),
      .rst_n(srst_n),
      .tick(sec_tick)
   );

   // identical channels, each with its own settings
   for (genvar g = 0; g < 2; g++) begin : g_chan
      dsat_channel u_chan (
         .clk(clk),
         .rst_n(srst_n),
         .process_value(process_value),
         .setpoint(sp_ff[g]),
         .band_width(band_ff[g]),
         .function_select(fn_ff[g]),
         .block_in(digital_in[g]),
         .hold_time(hold_ff[g]),
         .trigger_delay(dly_ff[g]),
         .sec_tick(sec_tick),
         .condition(cond[g]),
         .relay(relay[g]),
         .trig_pulse(trig[g]),
         .cond_rise(rise[g])
      );
   end

   assign events = {rise, trig};

   // ************************************************
   // outputs
   // ************************************************
   logic [1:0] relay_ff;
   logic [1:0] led_ff;
   logic irq_ff;

   // relays and leds are separate: leds ignore the timing
   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n) begin
         relay_ff <= 2'h0;
         led_ff <= 2'h0;
         irq_ff <= 1'b0;
      end else begin
         relay_ff <= relay;
         led_ff <= cond;
         irq_ff <= |(nxt_istat & nxt_mask);
      end
   end

   assign relay_out = relay_ff;
   assign chan1_indicator = led_ff[0];
   assign chan2_indicator = led_ff[1];
   assign irq = irq_ff;

   // ************************************************
   // read data
   // ************************************************
   logic [31:0] rd_val;
   logic [31:0] nxt_rdata;
   logic [31:0] rdata_ff;
   logic rd_ch;
   logic [4:0] rd_off;

   // read data registered at the address edge, shown next cycle
   always_comb begin
      rd_ch = haddr[5];
      rd_off = haddr[4:0];
      rd_val = 32'h00000000;
      if (addr_hi_zero && haddr[7:6] == 2'h0) begin
         case (rd_off)
            OFF_SETPOINT: rd_val = 32'(sp_ff[rd_ch]);
            OFF_FUNCTION: rd_val = {29'h0, fn_ff[rd_ch]};
            OFF_BAND: rd_val = 32'(band_ff[rd_ch]);
            OFF_HOLD: rd_val = {22'h0, hold_ff[rd_ch]};
            OFF_DELAY: rd_val = {22'h0, dly_ff[rd_ch]};
            default: rd_val = 32'h00000000;
         endcase
      end else if (addr_hi_zero) begin
         case (haddr[7:0])
            OFF_STATUS: rd_val = {28'h0, relay_ff, led_ff};
            OFF_IRQ_STAT: rd_val = {28'h0, istat_ff};
            OFF_IRQ_MASK: rd_val = {28'h0, mask_ff};
            default: rd_val = 32'h00000000;
         endcase
      end
      nxt_rdata = (addr_take && !hwrite) ? rd_val : 32'h00000000;
   end

   always_ff @(posedge clk or negedge srst_n) begin
      if (!srst_n)
         rdata_ff <= 32'h00000000;
      else
         rdata_ff <= nxt_rdata;
   end

   assign hrdata = rdata_ff;
endmodule : dsat_top

// file: dsat_top_bench.sv
// Purpose: register level tests of the alarm timer
// Assumes: zero wait states, one second shortened to 20 cycles
// Notes:   the partner supplies process value and block inputs
`timescale 1ns/1ns
module dsat_top_bench
   import dsat_pkg::*;
;
   localparam int TK = 20;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rv;
   logic hreadyout, hresp, irq, e;
   logic [1:0] relay_out, digital_in;
   logic chan1_indicator, chan2_indicator;
   logic signed [15:0] process_value;
   logic signed [15:0] pv_set = 16'sh0;
   logic blk_set = 1'b0;
   logic [4:0] x;
   int miscompares = 0;
   int total_checks = 0;
   int pvs [5] = '{89, 90, 100, 110, 111};
   // ********
   // clock, design, partner
   // ********
   always #2 clk = ~clk;
   dsat_top #(.TICK_CYCLES(TK)) i_dsat_top (
      .clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
      .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .process_value(process_value),
      .digital_in(digital_in), .relay_out(relay_out),
      .chan1_indicator(chan1_indicator),
      .chan2_indicator(chan2_indicator), .irq(irq));
   dsat_partner i_dsat_partner (
      .clk(clk), .rst_n(rst_n), .want_value(pv_set),
      .want_block(blk_set), .process_value(process_value),
      .digital_in(digital_in));
   // ********
   // tasks
   // ********
   task automatic final_report();
      if (miscompares == 0 && total_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : final_report
   task automatic note(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("wrong value at %0t: got %h exp %h", $time, got, exp);
      end
   endtask : note
   // one single transfer; waits for hready in both phases
   task automatic bus(input logic [31:0] a, input logic w,
      input logic [31:0] d);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge clk);
      while (hreadyout !== 1'b1) @(posedge clk);
      rv = hrdata;
   endtask : bus
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b1, d);
   endtask : wr
   task automatic check_reg(input logic [31:0] a, input logic [31:0] d);
      bus(a, 1'b0, 32'h0);
      note(rv, d);
   endtask : check_reg
   // pins as {irq, relay 2, relay 1, led 2, led 1}
   task automatic check_pin(input logic [4:0] d);
      note({27'h0, irq, relay_out, chan2_indicator, chan1_indicator},
         {27'h0, d});
   endtask : check_pin
   task automatic sat(input logic [31:0] a, input logic [31:0] w,
      input logic [31:0] d);
      wr(a, w);
      check_reg(a, d);
   endtask : sat
   task automatic drive(input int v, input logic b, input int n);
      @(posedge clk);
      pv_set <= 16'(v);
      blk_set <= b;
      repeat (n) @(posedge clk);
      #1;
   endtask : drive
   function automatic logic [31:0] ra(input int c, input logic [4:0] o);
      return 32'(c) * 32'(CH_STRIDE) + 32'(o);
   endfunction : ra
   // set point 100, width 20: window 90..110
   function automatic logic cond_of(input int f, input int v,
      input logic b);
      case (3'(f))
         FN_BELOW: return v < 100;
         FN_ABOVE: return v > 100;
         FN_BAND: return v < 90 || v > 110;
         FN_BELOW_BLK: return v < 100 && !b;
         FN_ABOVE_BLK: return v > 100 && !b;
         FN_BAND_BLK: return (v < 90 || v > 110) && !b;
         default: return 1'b0;
      endcase
   endfunction : cond_of
   // ********
   // tests
   // ********
   // the span is over twenty times the expected run
   initial begin
      repeat (30000) @(posedge clk);
      miscompares++;
      final_report();
   end
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge clk);
      for (int c = 0; c < 2; c++) begin
         for (int o = 0; o < 20; o += 4) begin
            check_reg(ra(c, 5'(o)), 32'h0);
         end
      end
      check_reg({24'h0, OFF_STATUS}, 32'h0);
      check_reg({24'h0, OFF_IRQ_MASK}, 32'h0);
      wr(32'h100, 32'hFFFF);
      check_reg(32'h100, 32'h0);
      check_reg(ra(0, OFF_SETPOINT), 32'h0);
      check_reg(32'h14, 32'h0);
      // every code on one channel while the other stays off
      for (int c = 0; c < 2; c++) begin
         wr(ra(c, OFF_SETPOINT), 32'h64);
         wr(ra(c, OFF_BAND), 32'h14);
         for (int f = 0; f < 8; f++) begin
            wr(ra(c, OFF_FUNCTION), 32'(f));
            for (int i = 0; i < 10; i++) begin
               drive(pvs[i % 5], i > 4, 5);
               e = cond_of(f, pvs[i % 5], i > 4);
               x = c ? {1'b0, e, 1'b0, e, 1'b0} : {2'h0, e, 1'b0, e};
               check_pin(x);
            end
         end
         wr(ra(c, OFF_FUNCTION), 32'(FN_OFF));
      end
      // delay of 2 s, trigger interrupt raised, masked and cleared
      check_reg({24'h0, OFF_IRQ_STAT}, 32'hF);
      drive(89, 1'b0, 2);
      wr({24'h0, OFF_IRQ_STAT}, 32'hF);
      wr({24'h0, OFF_IRQ_MASK}, 32'h1);
      wr(ra(0, OFF_FUNCTION), 32'(FN_ABOVE));
      wr(ra(0, OFF_DELAY), 32'h2);
      drive(111, 1'b0, 15);
      check_pin(5'h01);
      drive(111, 1'b0, 35);
      check_pin(5'h15);
      check_reg({24'h0, OFF_STATUS}, 32'h5);
      check_reg({24'h0, OFF_IRQ_STAT}, 32'h5);
      wr({24'h0, OFF_IRQ_MASK}, 32'h0);
      drive(111, 1'b0, 2);
      check_pin(5'h05);
      wr({24'h0, OFF_IRQ_MASK}, 32'h1);
      drive(111, 1'b0, 2);
      check_pin(5'h15);
      wr({24'h0, OFF_IRQ_STAT}, 32'h1);
      drive(111, 1'b0, 2);
      check_pin(5'h05);
      check_reg({24'h0, OFF_IRQ_STAT}, 32'h4);
      drive(89, 1'b0, 5);
      check_pin(5'h00);
      // hold of 2 s drops the relay while the condition stays
      wr(ra(0, OFF_DELAY), 32'h0);
      wr(ra(0, OFF_HOLD), 32'h2);
      drive(111, 1'b0, 12);
      check_pin(5'h15);
      drive(111, 1'b0, 50);
      check_pin(5'h11);
      drive(89, 1'b0, 5);
      drive(111, 1'b0, 5);
      check_pin(5'h15);
      // settings saturate at their range ends
      sat(ra(0, OFF_SETPOINT), 32'h9C40, 32'h7530);
      sat(ra(1, OFF_SETPOINT), 32'hFFFFB1E0, 32'hFFFFD8F1);
      sat(ra(0, OFF_BAND), 32'hFFFFB1E0, 32'hFFFFD8F1);
      sat(ra(1, OFF_BAND), 32'h9C40, 32'h7530);
      sat(ra(1, OFF_HOLD), 32'h7D0, 32'h3E8);
      sat(ra(1, OFF_DELAY), 32'hFFFFFFFF, 32'h3E8);
      final_report();
   end
endmodule : dsat_top_bench
